// file: rtl/dio_map.svh
// offsets, field positions, reset values and counts of the board map
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define DIO_SPAN 10'h00C
`define DIO_OFF_PORT_A 4'h0
`define DIO_OFF_PORT_B 4'h1
`define DIO_OFF_PORT_C 4'h2
`define DIO_OFF_PORT_CFG 4'h3
`define DIO_OFF_INT_EN 4'h4
`define DIO_OFF_INT_STAT 4'h5
`define DIO_OFF_CNT0 4'h8
`define DIO_OFF_CNT1 4'h9
`define DIO_OFF_CNT2 4'hA
`define DIO_OFF_CNT_CTRL 4'hB

// ****************************************************************
// port configuration fields
// ****************************************************************
`define DIO_CFG_SET_BIT 7
`define DIO_CFG_A_IN_BIT 4
`define DIO_CFG_CU_IN_BIT 3
`define DIO_CFG_B_IN_BIT 1
`define DIO_CFG_CL_IN_BIT 0
`define DIO_CFG_LINE_HI 3
`define DIO_CFG_LINE_LO 1
`define DIO_CFG_LEVEL_BIT 0
`define DIO_CFG_RESET 8'h9B
`define DIO_LATCH_RESET 8'h00

// ****************************************************************
// counter control fields
// ****************************************************************
`define DIO_CC_SEL_HI 7
`define DIO_CC_SEL_LO 6
`define DIO_CC_ACC_HI 5
`define DIO_CC_ACC_LO 4
`define DIO_CC_MODE_HI 3
`define DIO_CC_MODE_LO 1
`define DIO_CC_SEL_READBACK 2'h3
`define DIO_ACC_LATCH 2'h0
`define DIO_ACC_LSB 2'h1
`define DIO_ACC_MSB 2'h2
`define DIO_ACC_BOTH 2'h3
`define DIO_ACC_RESET 2'h3
`define DIO_MODE_TERMINAL 3'h0
`define DIO_MODE_RESET 3'h2

// ****************************************************************
// interrupt sources and timing
// ****************************************************************
`define DIO_SRC_CNT0 3'h0
`define DIO_SRC_CNT1 3'h1
`define DIO_SRC_CNT2 3'h2
`define DIO_SRC_PORT_A_HS 3'h3
`define DIO_SRC_PORT_B_HS 3'h4
`define DIO_SRC_EXT 3'h5
`define DIO_HS_A_LINE 3
`define DIO_HS_B_LINE 0
`define DIO_CNT_DIV 16

`endif

// file: rtl/dio_pkg.sv
// types shared by the board register logic
package dio_pkg;

  // one decoded host access, offset relative to the base
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] offset;
    logic [7:0] data;
  } dio_req_type;

  // direction of each port group, one means input
  typedef struct packed {
    logic a_in;
    logic cu_in;
    logic b_in;
    logic cl_in;
  } dio_dir_type;

endpackage

// file: rtl/dio_counter.sv
// one 16-bit down counter with byte-wide load and read
`timescale 1ns/10ps
`include "dio_map.svh"
module dio_counter
  import dio_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // count rate enable
  input wire logic tick,
  // control word for this counter
  input wire logic ctrl_wr,
  input wire logic [1:0] ctrl_access,
  input wire logic [2:0] ctrl_mode,
  // data location access
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic count_out
);

  logic [WIDTH-1:0] count_reg, reload_reg, latch_reg, reload_next;
  logic [1:0] access_reg;
  logic [2:0] mode_reg;
  logic wr_hi_reg, rd_hi_reg, latched_reg, run_reg, out_reg, load_done;
  logic [WIDTH-1:0] rd_src;
  logic rd_hi;

  // ****************************************************************
  // load assembly
  // ****************************************************************
  always_comb begin
    reload_next = reload_reg;
    load_done = 1'b0;
    unique case (access_reg)
      `DIO_ACC_LSB: begin
        reload_next = {{(WIDTH-8){1'b0}}, wdata};
        load_done = data_wr;
      end
      `DIO_ACC_MSB: begin
        reload_next = {wdata, reload_reg[7:0]} & {{8{1'b1}}, 8'h00};
        load_done = data_wr;
      end
      default: begin
        if (wr_hi_reg) begin
          reload_next = {wdata, reload_reg[7:0]};
        end else begin
          reload_next = {reload_reg[WIDTH-1:8], wdata};
        end
        load_done = data_wr & wr_hi_reg;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      access_reg <= `DIO_ACC_RESET;
      mode_reg <= `DIO_MODE_RESET;
      wr_hi_reg <= 1'b0;
      reload_reg <= '0;
    end else if (ctrl_wr && ctrl_access != `DIO_ACC_LATCH) begin
      access_reg <= ctrl_access;
      mode_reg <= ctrl_mode;
      wr_hi_reg <= 1'b0;
    end else if (data_wr) begin
      reload_reg <= reload_next;
      if (access_reg == `DIO_ACC_BOTH) begin
        wr_hi_reg <= ~wr_hi_reg;
      end
    end
  end

  // ****************************************************************
  // counting: starts on the first tick after the load completes
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= '0;
      run_reg <= 1'b0;
      out_reg <= 1'b0;
    end else if (load_done) begin
      count_reg <= reload_next; // [R16]
      run_reg <= 1'b1; // [R16]
      out_reg <= (mode_reg != `DIO_MODE_TERMINAL);
    end else if (ctrl_wr && ctrl_access != `DIO_ACC_LATCH) begin
      run_reg <= 1'b0;
      out_reg <= (ctrl_mode != `DIO_MODE_TERMINAL);
    end else if (tick && run_reg) begin
      if (mode_reg == `DIO_MODE_TERMINAL) begin
        count_reg <= count_reg - 1'b1;
        if (count_reg == {{(WIDTH-1){1'b0}}, 1'b1}) begin
          out_reg <= 1'b1;
        end
      end else if (count_reg == {{(WIDTH-1){1'b0}}, 1'b1}) begin
        // one low tick per period, so each period gives a rising edge
        count_reg <= reload_reg;
        out_reg <= 1'b0;
      end else begin
        count_reg <= count_reg - 1'b1;
        out_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // read path with count latch
  // ****************************************************************
  always_comb begin
    rd_src = latched_reg ? latch_reg : count_reg;
    rd_hi = (access_reg == `DIO_ACC_MSB) ||
            (access_reg == `DIO_ACC_BOTH && rd_hi_reg);
    rdata = rd_hi ? rd_src[WIDTH-1:8] : rd_src[7:0]; // [R15]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_hi_reg <= 1'b0;
      latched_reg <= 1'b0;
      latch_reg <= '0;
    end else if (ctrl_wr && ctrl_access == `DIO_ACC_LATCH) begin
      if (!latched_reg) begin
        latch_reg <= count_reg;
        latched_reg <= 1'b1;
      end
    end else if (ctrl_wr) begin
      rd_hi_reg <= 1'b0;
      latched_reg <= 1'b0;
    end else if (data_rd) begin
      if (access_reg == `DIO_ACC_BOTH) begin
        rd_hi_reg <= ~rd_hi_reg;
        if (rd_hi_reg) begin
          latched_reg <= 1'b0;
        end
      end else begin
        latched_reg <= 1'b0;
      end
    end
  end

  assign count_out = out_reg;

endmodule

// file: rtl/dio_port.sv
// three parallel ports with their configuration word
`timescale 1ns/10ps
`include "dio_map.svh"
module dio_port
  import dio_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // decoded host access
  input wire dio_req_type req,
  // external lines
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic [7:0] c_in,
  output logic [7:0] a_out,
  output logic [7:0] b_out,
  output logic [7:0] c_out,
  output logic [7:0] a_oe_n,
  output logic [7:0] b_oe_n,
  output logic [7:0] c_oe_n,
  // read data for the port locations
  output logic [7:0] rdata
);

  // a literal cannot be bit-selected, so the reset word is named first
  localparam logic [7:0] CFG_RESET = `DIO_CFG_RESET;

  dio_dir_type dir_reg;
  logic [7:0] a_reg, b_reg, c_reg;
  logic cfg_wr;
  logic [2:0] line;

  assign cfg_wr = req.wr && req.offset == `DIO_OFF_PORT_CFG;
  assign line = req.data[`DIO_CFG_LINE_HI:`DIO_CFG_LINE_LO];

  // ****************************************************************
  // configuration word
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      dir_reg <= {CFG_RESET[`DIO_CFG_A_IN_BIT],
                  CFG_RESET[`DIO_CFG_CU_IN_BIT],
                  CFG_RESET[`DIO_CFG_B_IN_BIT],
                  CFG_RESET[`DIO_CFG_CL_IN_BIT]};
    end else if (cfg_wr && req.data[`DIO_CFG_SET_BIT]) begin // [R5]
      // mode bits are not kept: only basic mode exists here
      dir_reg.a_in <= req.data[`DIO_CFG_A_IN_BIT]; // [R7] [R8]
      dir_reg.cu_in <= req.data[`DIO_CFG_CU_IN_BIT]; // [R8]
      dir_reg.b_in <= req.data[`DIO_CFG_B_IN_BIT]; // [R8]
      dir_reg.cl_in <= req.data[`DIO_CFG_CL_IN_BIT]; // [R8]
    end
  end

  // ****************************************************************
  // output latches
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      a_reg <= `DIO_LATCH_RESET;
      b_reg <= `DIO_LATCH_RESET;
      c_reg <= `DIO_LATCH_RESET;
    end else if (cfg_wr && req.data[`DIO_CFG_SET_BIT]) begin
      a_reg <= `DIO_LATCH_RESET;
      b_reg <= `DIO_LATCH_RESET;
      c_reg <= `DIO_LATCH_RESET;
    end else if (cfg_wr) begin
      c_reg[line] <= req.data[`DIO_CFG_LEVEL_BIT]; // [R9] [R10]
    end else if (req.wr) begin
      if (req.offset == `DIO_OFF_PORT_A) begin
        a_reg <= req.data; // [R2]
      end
      if (req.offset == `DIO_OFF_PORT_B) begin
        b_reg <= req.data; // [R3]
      end
      if (req.offset == `DIO_OFF_PORT_C) begin
        c_reg <= req.data; // [R4]
      end
    end
  end

  // ****************************************************************
  // buffer direction and read data
  // ****************************************************************
  assign a_out = a_reg;
  assign b_out = b_reg;
  assign c_out = c_reg;
  assign a_oe_n = {8{dir_reg.a_in}}; // [R18]
  assign b_oe_n = {8{dir_reg.b_in}}; // [R18]
  assign c_oe_n = {{4{dir_reg.cu_in}}, {4{dir_reg.cl_in}}}; // [R18]

  always_comb begin
    unique case (req.offset)
      `DIO_OFF_PORT_A: rdata = dir_reg.a_in ? a_in : a_reg; // [R2]
      `DIO_OFF_PORT_B: rdata = dir_reg.b_in ? b_in : b_reg; // [R3]
      `DIO_OFF_PORT_C: begin
        rdata = {dir_reg.cu_in ? c_in[7:4] : c_reg[7:4],
                 dir_reg.cl_in ? c_in[3:0] : c_reg[3:0]}; // [R4]
      end
      default: rdata = 8'h00;
    endcase
  end

endmodule

// file: rtl/dio_top.sv
// board register decoder: host i/o locations, ports, counters, interrupt
//
// Contract
// [R1] decode twelve consecutive byte locations from the switch-selected base
// [R2] offset 0 reads port A inputs, writes port A outputs
// [R3] offset 1 reads port B inputs, writes port B outputs
// [R4] offset 2 accesses port C as two halves with own direction
// [R5] config write with bit 7 set loads a new port configuration
// [R6] host always writes config bit 6 as zero
// [R7] basic mode configurations run from 80 to 9B hex
// [R8] bits 4,3,1,0 make port A, C upper, B, C lower inputs
// [R9] config write with bit 7 clear sets or clears one port C line
// [R10] bits 3..1 pick the port C line, bit 0 its level
// [R11] offset 4 write of one enables, zero disables interrupts
// [R12] offset 5 read shows the pending flag in bit 0
// [R13] any write to offset 5 clears the pending flag; here an enabled rising edge in the same cycle keeps it set
// [R14] host clears the pending flag after each time it sets
// [R15] offsets 8, 9, 10 read the three counters' counts
// [R16] counter write loads it and counting starts once loaded
// [R17] offset 11 write goes to the shared counter control word
// [R18] line buffer direction follows the latest port configuration
// [R19] enabled rising edge of source raises interrupt line and flag
// [R20] interrupt source is one of six selectable signals
// [R21] host uses byte-wide accesses only
// [R22] reserved and write-only locations read zero, reserved writes ignored
`timescale 1ns/10ps
`include "dio_map.svh"
module dio_top
  import dio_pkg::*;
#(
  parameter int ADDR_WIDTH = 10,
  parameter int CNT_WIDTH = 16,
  parameter int CNT_DIV = `DIO_CNT_DIV
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // host i/o bus
  input wire logic [ADDR_WIDTH-1:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  input wire logic IO_RD,
  input wire logic IO_WR,
  output logic IO_SELECTED,
  output logic [7:0] IO_RDATA,
  output logic IO_RDATA_VALID,
  // board settings
  input wire logic [ADDR_WIDTH-1:0] BASE_SELECT_SWITCH,
  input wire logic [2:0] INT_SOURCE_SELECT,
  // digital lines of the main and aux io connectors
  input wire logic [7:0] PORT_A_IN,
  output logic [7:0] PORT_A_OUT,
  output logic [7:0] PORT_A_OE_N,
  input wire logic [7:0] PORT_B_IN,
  output logic [7:0] PORT_B_OUT,
  output logic [7:0] PORT_B_OE_N,
  input wire logic [7:0] PORT_C_IN,
  output logic [7:0] PORT_C_OUT,
  output logic [7:0] PORT_C_OE_N,
  // counters and interrupt
  output logic [2:0] COUNTER_OUT,
  input wire logic EXTERNAL_INTERRUPT_INPUT,
  output logic IRQ
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic in_window(input logic [ADDR_WIDTH-1:0] addr,
                                     input logic [ADDR_WIDTH-1:0] base);
    logic [ADDR_WIDTH:0] rel;
    rel = {1'b0, addr} - {1'b0, base};
    in_window = (addr >= base) &&
                (rel < {1'b0, ADDR_WIDTH'(`DIO_SPAN)});
  endfunction

  logic hit;
  logic [ADDR_WIDTH-1:0] rel_addr;
  dio_req_type req;

  assign hit = in_window(IO_ADDR, BASE_SELECT_SWITCH); // [R1]
  assign rel_addr = IO_ADDR - BASE_SELECT_SWITCH;
  assign req.rd = IO_RD & hit; // [R1]
  assign req.wr = IO_WR & hit; // [R1]
  assign req.offset = rel_addr[3:0];
  assign req.data = IO_WDATA;
  assign IO_SELECTED = hit;

  // ****************************************************************
  // parallel ports
  // ****************************************************************
  logic [7:0] port_rdata;

  dio_port u_port (
    .clk(CLK_SYS),
    .reset(RESET),
    .req(req),
    .a_in(PORT_A_IN),
    .b_in(PORT_B_IN),
    .c_in(PORT_C_IN),
    .a_out(PORT_A_OUT),
    .b_out(PORT_B_OUT),
    .c_out(PORT_C_OUT),
    .a_oe_n(PORT_A_OE_N),
    .b_oe_n(PORT_B_OE_N),
    .c_oe_n(PORT_C_OE_N),
    .rdata(port_rdata)
  );

  // ****************************************************************
  // count rate divider
  // ****************************************************************
  logic [15:0] div_reg;
  logic tick;

  assign tick = (div_reg == 16'(CNT_DIV - 1));

  always_ff @(posedge CLK_SYS) begin
    if (RESET || tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // ****************************************************************
  // counters and shared control word
  // ****************************************************************
  logic cc_wr;
  logic [1:0] cc_sel;
  logic [2:0] cnt_ctrl_wr, cnt_data_wr, cnt_data_rd, cnt_out;
  logic [7:0] cnt_rdata [3];

  assign cc_wr = req.wr && req.offset == `DIO_OFF_CNT_CTRL; // [R17]
  assign cc_sel = IO_WDATA[`DIO_CC_SEL_HI:`DIO_CC_SEL_LO];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cnt
      localparam logic [3:0] OFF = `DIO_OFF_CNT0 + 4'(gi);
      assign cnt_ctrl_wr[gi] = cc_wr && cc_sel == 2'(gi); // [R17]
      assign cnt_data_wr[gi] = req.wr && req.offset == OFF; // [R16]
      assign cnt_data_rd[gi] = req.rd && req.offset == OFF; // [R15]
      dio_counter #(
        .WIDTH(CNT_WIDTH)
      ) u_cnt (
        .clk(CLK_SYS),
        .reset(RESET),
        .tick(tick),
        .ctrl_wr(cnt_ctrl_wr[gi]),
        .ctrl_access(IO_WDATA[`DIO_CC_ACC_HI:`DIO_CC_ACC_LO]),
        .ctrl_mode(IO_WDATA[`DIO_CC_MODE_HI:`DIO_CC_MODE_LO]),
        .data_wr(cnt_data_wr[gi]),
        .data_rd(cnt_data_rd[gi]),
        .wdata(IO_WDATA),
        .rdata(cnt_rdata[gi]),
        .count_out(cnt_out[gi])
      );
    end
  endgenerate

  assign COUNTER_OUT = cnt_out;

  // ****************************************************************
  // interrupt
  // ****************************************************************
  logic int_en_reg, pending_reg, src_reg, src;

  always_comb begin
    unique case (INT_SOURCE_SELECT) // [R20]
      `DIO_SRC_CNT0: src = cnt_out[0];
      `DIO_SRC_CNT1: src = cnt_out[1];
      `DIO_SRC_CNT2: src = cnt_out[2];
      `DIO_SRC_PORT_A_HS: src = PORT_C_IN[`DIO_HS_A_LINE];
      `DIO_SRC_PORT_B_HS: src = PORT_C_IN[`DIO_HS_B_LINE];
      `DIO_SRC_EXT: src = EXTERNAL_INTERRUPT_INPUT;
      default: src = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      int_en_reg <= 1'b0;
    end else if (req.wr && req.offset == `DIO_OFF_INT_EN) begin
      int_en_reg <= IO_WDATA[0]; // [R11]
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      src_reg <= 1'b0;
    end else begin
      src_reg <= src;
    end
  end

  // a new edge wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pending_reg <= 1'b0;
    end else if (int_en_reg && src && !src_reg) begin
      pending_reg <= 1'b1; // [R19]
    end else if (req.wr && req.offset == `DIO_OFF_INT_STAT) begin
      pending_reg <= 1'b0; // [R13]
    end
  end

  assign IRQ = pending_reg; // [R19]

  // ****************************************************************
  // read data
  // ****************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      IO_RDATA <= 8'h00;
      IO_RDATA_VALID <= 1'b0;
    end else begin
      IO_RDATA_VALID <= req.rd;
      if (req.rd) begin
        unique case (req.offset)
          `DIO_OFF_PORT_A, `DIO_OFF_PORT_B, `DIO_OFF_PORT_C: begin
            IO_RDATA <= port_rdata; // [R2] [R3] [R4]
          end
          `DIO_OFF_INT_STAT: IO_RDATA <= {7'h00, pending_reg}; // [R12]
          `DIO_OFF_CNT0: IO_RDATA <= cnt_rdata[0]; // [R15]
          `DIO_OFF_CNT1: IO_RDATA <= cnt_rdata[1]; // [R15]
          `DIO_OFF_CNT2: IO_RDATA <= cnt_rdata[2]; // [R15]
          default: IO_RDATA <= 8'h00; // [R22]
        endcase
      end
    end
  end

endmodule

// file: test/dio_top_monitor.sv
// checker of the board register decoder at its ports
`timescale 1ns/10ps
module dio_top_monitor
  import dio_pkg::*;
#(
  parameter int ADDR_WIDTH = 10
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // host bus
  input wire logic [ADDR_WIDTH-1:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  input wire logic IO_RD,
  input wire logic IO_WR,
  input wire logic IO_SELECTED,
  input wire logic [7:0] IO_RDATA,
  input wire logic IO_RDATA_VALID,
  // settings and lines
  input wire logic [ADDR_WIDTH-1:0] BASE_SELECT_SWITCH,
  input wire logic [2:0] INT_SOURCE_SELECT,
  input wire logic [7:0] PORT_A_IN,
  input wire logic [7:0] PORT_A_OUT,
  input wire logic [7:0] PORT_A_OE_N,
  input wire logic [7:0] PORT_C_IN,
  input wire logic [7:0] PORT_C_OUT,
  input wire logic [2:0] COUNTER_OUT,
  input wire logic EXTERNAL_INTERRUPT_INPUT,
  input wire logic IRQ
);
  logic [ADDR_WIDTH-1:0] off;
  logic [3:0] o;
  logic win, src, src_prev, en_reg, hit;
  assign off = IO_ADDR - BASE_SELECT_SWITCH;
  assign win = off < 12;
  assign o = off[3:0];
  assign src = INT_SOURCE_SELECT < 3'h3 ? COUNTER_OUT[INT_SOURCE_SELECT[1:0]]
    : INT_SOURCE_SELECT == 3'h3 ? PORT_C_IN[3]
    : INT_SOURCE_SELECT == 3'h4 ? PORT_C_IN[0]
    : INT_SOURCE_SELECT == 3'h5 && EXTERNAL_INTERRUPT_INPUT;
  assign hit = src && !src_prev && en_reg;
  always_ff @(posedge CLK_SYS) begin
    src_prev <= src;
  end
  // enable latch seen from the bus
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      en_reg <= 1'b0;
    end else if (IO_WR && win && o == 4'h4) begin
      en_reg <= IO_WDATA[0];
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  a_window_decode: assert property (IO_SELECTED == win)
    else $error("select differs from window");
  a_read_answer: assert property (IO_RD && win |=> IO_RDATA_VALID)
    else $error("read without valid");
  a_stray_valid: assert property (!(IO_RD && win) |=> !IO_RDATA_VALID)
    else $error("valid without read");
  a_port_a_read: assert property (IO_RD && win && o == 4'h0 &&
    &PORT_A_OE_N |=> IO_RDATA == $past(PORT_A_IN))
    else $error("port a read wrong");
  a_cfg_dirs: assert property (IO_WR && win && o == 4'h3 &&
    IO_WDATA[7] |=> PORT_A_OE_N == {8{$past(IO_WDATA[4])}})
    else $error("port a direction wrong");
  a_line_write: assert property (IO_WR && win && o == 4'h3 &&
    !IO_WDATA[7] |=> PORT_C_OUT[$past(IO_WDATA[3:1])] == $past(IO_WDATA[0])
    && $stable(PORT_A_OE_N))
    else $error("single line write wrong");
  a_irq_raise: assert property (hit |=> IRQ)
    else $error("interrupt not raised");
  a_irq_clear: assert property (IO_WR && win && o == 4'h5 && !hit
    |=> !IRQ)
    else $error("interrupt not cleared");
  a_irq_quiet: assert property (!IRQ && !hit |=> !IRQ)
    else $error("interrupt without cause");
  a_status_bits: assert property (IO_RD && win && o == 4'h5
    |=> IO_RDATA[7:1] == 7'h00)
    else $error("status upper bits set");
  a_blank_read: assert property (IO_RD && win && (o == 4'h3 ||
    o == 4'h4 || o == 4'h6 || o == 4'h7 || o == 4'hB) |=> IO_RDATA == 8'h00)
    else $error("blank location read nonzero");
  c_irq: cover property (hit);
  c_cnt_read: cover property (IO_RD && win && o == 4'h8);
  c_line: cover property (IO_WR && win && o == 4'h3 && !IO_WDATA[7]);
endmodule

bind dio_top dio_top_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) u_mon (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
  .IO_RD(IO_RD), .IO_WR(IO_WR), .IO_SELECTED(IO_SELECTED),
  .IO_RDATA(IO_RDATA), .IO_RDATA_VALID(IO_RDATA_VALID),
  .BASE_SELECT_SWITCH(BASE_SELECT_SWITCH),
  .INT_SOURCE_SELECT(INT_SOURCE_SELECT), .PORT_A_IN(PORT_A_IN),
  .PORT_A_OUT(PORT_A_OUT), .PORT_A_OE_N(PORT_A_OE_N), .PORT_C_IN(PORT_C_IN),
  .PORT_C_OUT(PORT_C_OUT), .COUNTER_OUT(COUNTER_OUT),
  .EXTERNAL_INTERRUPT_INPUT(EXTERNAL_INTERRUPT_INPUT), .IRQ(IRQ));

// file: test/dio_host.sv
// host bus model issuing byte accesses to the board
`timescale 1ns/10ps
module dio_host #(
  parameter int AW = 10
) (
  // clock
  input wire logic clk,
  // bus
  output logic [AW-1:0] addr,
  output logic [7:0] wdata,
  output logic rd_stb,
  output logic wr_stb,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid
);
  initial begin
    addr = '0;
    wdata = 8'h00;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
  end
  // one byte per strobe, never a word access
  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    @(negedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(negedge clk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // answer is registered on the taking edge and sampled half a cycle later
  task automatic rd(input logic [AW-1:0] a, output logic [7:0] d,
                    output logic ok);
    @(negedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(negedge clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    ok = rdata_valid;
    d = rdata;
  endtask
endmodule

// file: test/dio_top_tb.sv
// self-checking bench of the board register decoder
`timescale 1ns/10ps
module dio_top_tb;
  import dio_pkg::*;
  localparam logic [9:0] BASE = 10'h1F6;
  logic clk_sys = 1'b0, rst = 1'b1, rd, wr, sel, vld, irq, ext_int = 1'b0;
  logic [9:0] addr;
  logic [7:0] wd, rdat, a_in, a_out, a_oe_n, b_in, b_out, b_oe_n;
  logic [7:0] c_in, c_out, c_oe_n, cfg, d;
  logic [7:0] ext_a = 8'hA5, ext_b = 8'h3C, ext_c = 8'h69;
  logic [2:0] cnt_out, sel_src = 3'h7;
  logic ok;
  int fail_count = 0, total_checks = 0, n;
  int blank[5] = '{3, 4, 6, 7, 11};
  always #4 clk_sys = ~clk_sys;
  // driven lines read back the inverse of the driven output level
  assign a_in = (ext_a & a_oe_n) | (~a_out & ~a_oe_n);
  assign b_in = (ext_b & b_oe_n) | (~b_out & ~b_oe_n);
  assign c_in = (ext_c & c_oe_n) | (~c_out & ~c_oe_n);
  dio_host u_host (.clk(clk_sys), .addr(addr), .wdata(wd), .rd_stb(rd),
    .wr_stb(wr), .rdata(rdat), .rdata_valid(vld));
  dio_top #(.CNT_DIV(2)) dut (.CLK_SYS(clk_sys), .RESET(rst), .IO_ADDR(addr),
    .IO_WDATA(wd), .IO_RD(rd), .IO_WR(wr), .IO_SELECTED(sel),
    .IO_RDATA(rdat), .IO_RDATA_VALID(vld), .BASE_SELECT_SWITCH(BASE),
    .INT_SOURCE_SELECT(sel_src), .PORT_A_IN(a_in), .PORT_A_OUT(a_out),
    .PORT_A_OE_N(a_oe_n), .PORT_B_IN(b_in), .PORT_B_OUT(b_out),
    .PORT_B_OE_N(b_oe_n), .PORT_C_IN(c_in), .PORT_C_OUT(c_out),
    .PORT_C_OE_N(c_oe_n), .COUNTER_OUT(cnt_out),
    .EXTERNAL_INTERRUPT_INPUT(ext_int), .IRQ(irq));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic w(input int off, input logic [7:0] v);
    u_host.wr(BASE + 10'(off), v);
  endtask
  task automatic rdx(input int off, input logic [7:0] exp, input string nm);
    u_host.rd(BASE + 10'(off), d, ok);
    check("valid", 8'(ok), 8'h01);
    check(nm, d, exp);
  endtask
  task automatic set_src(input int s, input logic v);
    @(negedge clk_sys);
    if (s == 3) ext_c[3] = v;
    else if (s == 4) ext_c[0] = v;
    else ext_int = v;
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    check("oe_c_reset", c_oe_n, 8'hFF);
    for (int k = 0; k < 5; k++) rdx(blank[k], 8'h00, "blank");
    u_host.rd(BASE + 10'd12, d, ok);
    check("past_top", 8'(ok), 8'h00);
    u_host.rd(BASE - 10'd1, d, ok);
    check("below_base", 8'(ok), 8'h00);
    for (int k = 0; k < 16; k++) begin
      // bit 6 always written as zero
      cfg = 8'h80 | {3'h0, k[3], k[2], 1'b0, k[1], k[0]};
      w(3, cfg);
      check("oe_a", a_oe_n, {8{k[3]}});
      check("oe_b", b_oe_n, {8{k[1]}});
      check("oe_c", c_oe_n, {{4{k[2]}}, {4{k[0]}}});
      w(0, 8'h5A);
      check("out_a", a_out, 8'h5A);
      w(1, 8'hC3);
      check("out_b", b_out, 8'hC3);
      w(2, 8'h96);
      rdx(0, k[3] ? ext_a : 8'h5A, "port_a");
      rdx(1, k[1] ? ext_b : 8'hC3, "port_b");
      rdx(2, {k[2] ? ext_c[7:4] : 4'h9, k[0] ? ext_c[3:0] : 4'h6}, "c");
    end
    w(3, 8'h80);
    for (int i = 0; i < 8; i++) begin
      w(3, {4'h0, 3'(i), 1'b1});
      check("line_set", c_out, 8'((2 << i) - 1));
    end
    w(3, 8'h0A);
    rdx(2, 8'hDF, "line_clear");
    w(3, 8'h9B);
    ext_c = 8'h00;
    for (int s = 3; s < 6; s++) begin
      sel_src = 3'(s);
      w(4, 8'h01);
      set_src(s, 1'b1);
      repeat (3) @(negedge clk_sys);
      check("irq_set", 8'(irq), 8'h01);
      rdx(5, 8'h01, "status");
      w(5, 8'hA5);
      check("irq_clear", 8'(irq), 8'h00);
      set_src(s, 1'b0);
      w(4, 8'h00);
      set_src(s, 1'b1);
      repeat (3) @(negedge clk_sys);
      check("irq_masked", 8'(irq), 8'h00);
      set_src(s, 1'b0);
    end
    for (int i = 0; i < 3; i++) begin
      sel_src = 3'(i);
      w(11, {2'(i), 2'h3, 3'h2, 1'b0});
      check("out_mode2", 8'(cnt_out[i]), 8'h01);
      w(11, {2'(i), 2'h3, 3'h0, 1'b0});
      check("out_mode0", 8'(cnt_out[i]), 8'h00);
      w(4, 8'h01);
      w(8 + i, 8'h20);
      w(8 + i, 8'h00);
      u_host.rd(BASE + 10'(8 + i), d, ok);
      check("count_lo", 8'(d <= 8'h20 && d > 8'h10), 8'h01);
      rdx(8 + i, 8'h00, "count_hi");
      check("no_early_out", 8'(cnt_out[i]), 8'h00);
      for (n = 0; n < 200 && cnt_out[i] !== 1'b1; n++) @(negedge clk_sys);
      check("terminal", 8'(cnt_out[i]), 8'h01);
      if (n == 200) tally_and_finish();
      repeat (2) @(negedge clk_sys);
      check("irq_cnt", 8'(irq), 8'h01);
      w(5, 8'h00);
      w(4, 8'h00);
    end
    tally_and_finish();
  end
endmodule
